/* File: include/video_regs_pkg.sv */
// Purpose: Shared constants and carriers for the back-end video settings bank
// Assumes: Subaddress write port delivered by an upstream control-bus slave
// Notes:   Decoded settings travel as one packed struct
`default_nettype none
package video_regs_pkg;
	// Subaddresses
	localparam logic [7:0] ADDR_SHAPE     = 8'h39;
	localparam logic [7:0] ADDR_NOISE     = 8'h3A;
	localparam logic [7:0] ADDR_CHROMA    = 8'h3B;
	localparam logic [7:0] ADDR_LUMA      = 8'h3C;
	localparam logic [7:0] ADDR_BEGIN     = 8'h3D;
	localparam logic [7:0] ADDR_END       = 8'h3E;
	localparam logic [7:0] ADDR_FORMAT    = 8'h3F;
	// Field positions
	localparam int TAU_LSB        = 0;
	localparam int AMP_LSB        = 3;
	localparam int UNDER_LSB      = 5;
	localparam int THR_LSB        = 0;
	localparam int FILL_U_LSB     = 0;
	localparam int FILL_V_LSB     = 4;
	localparam int FDEL_LSB       = 0;
	localparam int RANGE_BIT      = 2;
	localparam int INV_BIT        = 3;
	localparam int YDEL_LSB       = 4;
	// Writable-bit masks; reserved bits read as zero
	localparam logic [7:0] MASK_SHAPE  = 8'h7F;
	localparam logic [7:0] MASK_NOISE  = 8'h0F;
	localparam logic [7:0] MASK_FORMAT = 8'h7F;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// Threshold step in LSB
	localparam logic [6:0] THR_STEP = 7'h08;
	// Output levels
	localparam logic [9:0] BLACK_9BIT  = 10'h120;
	localparam logic [9:0] WHITE_9BIT  = 10'h2FF;
	localparam logic [9:0] BLACK_10BIT = 10'h040;
	localparam logic [9:0] WHITE_10BIT = 10'h3FF;
	localparam int LUMA_DELAY_MAX = 7;

	typedef struct packed {
		logic [3:0] time_const_16th;   // tau in sixteenths
		logic [2:0] amplitude_atten_4th;
		logic [2:0] undershoot_atten_4th;
		logic [6:0] noise_threshold;   // magnitude in LSB
		logic [3:0] fill_u;
		logic [3:0] fill_v;
		logic [7:0] fill_y;
		logic [7:0] begin_pos;
		logic [7:0] end_pos;
		logic [1:0] border_fine_delay;
		logic       range_10bit;
		logic [9:0] black_level;
		logic [9:0] white_level;
		logic       chroma_invert;
		logic [2:0] luma_advance;      // cycles luma leads chroma
	} settings_t;

	typedef struct packed {
		logic [7:0] shape;
		logic [7:0] noise;
		logic [7:0] chroma;
		logic [7:0] luma;
		logic [7:0] begin_pos;
		logic [7:0] end_pos;
		logic [7:0] format;
		logic [7:0] rdata;
	} bank_state_t;
endpackage
`default_nettype wire

/* File: logic/luma_align_delay.sv */
// Purpose: Variable luma delay line, 1 to 8 pixel cycles
// Assumes: Enable pulse marks each output pixel clock cycle
// Notes:   Depth fixed at the eight-cycle chroma latency
`default_nettype none
module luma_align_delay (
	// Clock, reset and pixel enable
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        pix_en_in,
	// Data
	input  wire logic [9:0]  luma_in,
	input  wire logic [2:0]  delay_in,
	output logic      [9:0]  luma_out
);
	typedef struct packed {
		logic [7:0][9:0] taps;
		logic [9:0]      q;
	} line_t;
	line_t cur_ff;
	line_t nxt_ff;

	always_comb begin
		nxt_ff = cur_ff;
		if (pix_en_in) begin
			nxt_ff.taps = {cur_ff.taps[6:0], luma_in};
			nxt_ff.q    = (delay_in == 3'h0) ? luma_in : cur_ff.taps[delay_in - 3'h1];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign luma_out = cur_ff.q;
endmodule
`default_nettype wire

/* File: logic/video_peaking_panel_output_regs.sv */
// Purpose: Settings bank for peaking, border overlay and output format
// Assumes: Subaddress byte writes and reads from the control-bus slave
// Notes:   Settings decoded into a struct; luma aligned by a delay line
`default_nettype none
module video_peaking_panel_output_regs (
	// Clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       rst_n_in,
	// Register port
	input  wire logic                       reg_wr_in,
	input  wire logic                       reg_rd_in,
	input  wire logic [7:0]                 reg_addr_in,
	input  wire logic [7:0]                 reg_wdata_in,
	output logic      [7:0]                 reg_rdata_out,
	output logic                            reg_hit_out,
	// Pixel path
	input  wire logic                       pix_en_in,
	input  wire logic [9:0]                 luma_in,
	input  wire logic [7:0]                 chroma_u_in,
	input  wire logic [7:0]                 chroma_v_in,
	output logic      [9:0]                 luma_out,
	output logic      [7:0]                 chroma_u_out,
	output logic      [7:0]                 chroma_v_out,
	// Decoded settings
	output video_regs_pkg::settings_t       settings_out
);
	video_regs_pkg::bank_state_t cur_ff;
	video_regs_pkg::bank_state_t nxt_ff;
	video_regs_pkg::settings_t   set_c;
	logic [7:0]                  uv_u_ff;
	logic [7:0]                  uv_v_ff;
	logic                        hit_c;

	// Reserved bits are masked so they read back as zero
	always_comb begin
		nxt_ff = cur_ff;
		hit_c  = 1'b1;
		unique case (reg_addr_in)
			video_regs_pkg::ADDR_SHAPE:  nxt_ff.rdata = cur_ff.shape;
			video_regs_pkg::ADDR_NOISE:  nxt_ff.rdata = cur_ff.noise;
			video_regs_pkg::ADDR_CHROMA: nxt_ff.rdata = cur_ff.chroma;
			video_regs_pkg::ADDR_LUMA:   nxt_ff.rdata = cur_ff.luma;
			video_regs_pkg::ADDR_BEGIN:  nxt_ff.rdata = cur_ff.begin_pos;
			video_regs_pkg::ADDR_END:    nxt_ff.rdata = cur_ff.end_pos;
			video_regs_pkg::ADDR_FORMAT: nxt_ff.rdata = cur_ff.format;
			default: begin
				nxt_ff.rdata = 8'h00;
				hit_c        = 1'b0;
			end
		endcase
		if (!reg_rd_in) begin
			nxt_ff.rdata = cur_ff.rdata;
		end
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				video_regs_pkg::ADDR_SHAPE:  nxt_ff.shape     = reg_wdata_in & video_regs_pkg::MASK_SHAPE;
				video_regs_pkg::ADDR_NOISE:  nxt_ff.noise     = reg_wdata_in & video_regs_pkg::MASK_NOISE;
				video_regs_pkg::ADDR_CHROMA: nxt_ff.chroma    = reg_wdata_in;
				video_regs_pkg::ADDR_LUMA:   nxt_ff.luma      = reg_wdata_in;
				video_regs_pkg::ADDR_BEGIN:  nxt_ff.begin_pos = reg_wdata_in;
				video_regs_pkg::ADDR_END:    nxt_ff.end_pos   = reg_wdata_in;
				video_regs_pkg::ADDR_FORMAT: nxt_ff.format    = reg_wdata_in & video_regs_pkg::MASK_FORMAT;
				default:                     nxt_ff.rdata     = nxt_ff.rdata;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// Decode of the stored fields into working settings
	always_comb begin
		set_c = '0;
		unique case (cur_ff.shape[video_regs_pkg::TAU_LSB +: 3])
			3'h7:    set_c.time_const_16th = 4'h8;
			default: set_c.time_const_16th = {1'b0, cur_ff.shape[video_regs_pkg::TAU_LSB +: 3]};
		endcase
		unique case (cur_ff.shape[video_regs_pkg::AMP_LSB +: 2])
			2'h3:    set_c.amplitude_atten_4th = 3'h4;
			default: set_c.amplitude_atten_4th = {1'b0, cur_ff.shape[video_regs_pkg::AMP_LSB +: 2]};
		endcase
		unique case (cur_ff.shape[video_regs_pkg::UNDER_LSB +: 2])
			2'h3:    set_c.undershoot_atten_4th = 3'h4;
			default: set_c.undershoot_atten_4th = {1'b0, cur_ff.shape[video_regs_pkg::UNDER_LSB +: 2]};
		endcase
		set_c.noise_threshold = 7'(cur_ff.noise[video_regs_pkg::THR_LSB +: 4] * video_regs_pkg::THR_STEP);
		set_c.fill_u          = cur_ff.chroma[video_regs_pkg::FILL_U_LSB +: 4];
		set_c.fill_v          = cur_ff.chroma[video_regs_pkg::FILL_V_LSB +: 4];
		set_c.fill_y          = cur_ff.luma;
		set_c.begin_pos       = cur_ff.begin_pos;
		set_c.end_pos         = cur_ff.end_pos;
		set_c.border_fine_delay = cur_ff.format[video_regs_pkg::FDEL_LSB +: 2];
		set_c.range_10bit     = cur_ff.format[video_regs_pkg::RANGE_BIT];
		if (cur_ff.format[video_regs_pkg::RANGE_BIT]) begin
			set_c.black_level = video_regs_pkg::BLACK_10BIT;
			set_c.white_level = video_regs_pkg::WHITE_10BIT;
		end else begin
			set_c.black_level = video_regs_pkg::BLACK_9BIT;
			set_c.white_level = video_regs_pkg::WHITE_9BIT;
		end
		set_c.chroma_invert   = cur_ff.format[video_regs_pkg::INV_BIT];
		// Code 0 means luma seven cycles early, code 7 means aligned
		set_c.luma_advance    = 3'(video_regs_pkg::LUMA_DELAY_MAX) - cur_ff.format[video_regs_pkg::YDEL_LSB +: 3];
	end

	// Chroma has a fixed eight-cycle latency; luma one to eight cycles
	logic [6:0][15:0] uv_pipe_ff;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			uv_pipe_ff <= '0;
			uv_u_ff    <= 8'h00;
			uv_v_ff    <= 8'h00;
		end else if (pix_en_in) begin
			uv_pipe_ff <= {uv_pipe_ff[5:0], chroma_u_in, chroma_v_in};
			if (set_c.chroma_invert) begin
				uv_u_ff <= ~uv_pipe_ff[6][15:8];
				uv_v_ff <= ~uv_pipe_ff[6][7:0];
			end else begin
				uv_u_ff <= uv_pipe_ff[6][15:8];
				uv_v_ff <= uv_pipe_ff[6][7:0];
			end
		end
	end

	luma_align_delay luma_align_delay_inst (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.pix_en_in (pix_en_in),
		.luma_in   (luma_in),
		.delay_in  (cur_ff.format[video_regs_pkg::YDEL_LSB +: 3]),
		.luma_out  (luma_out)
	);

	assign reg_rdata_out = cur_ff.rdata;
	assign reg_hit_out   = hit_c;
	assign chroma_u_out  = uv_u_ff;
	assign chroma_v_out  = uv_v_ff;
	assign settings_out  = set_c;
endmodule
`default_nettype wire

/* File: sim/video_regs_monitor.sv */
// Purpose: Port assertions for the settings bank
// Assumes: Bound to the bank top module
// Notes:   Decode is checked one edge after each write to 0x39, 0x3A, 0x3B or 0x3F
`default_nettype none
module video_regs_monitor (
	// Watched ports
	input wire logic                      clk_in,
	input wire logic                      rst_n_in,
	input wire logic                      reg_wr_in,
	input wire logic                      reg_rd_in,
	input wire logic [7:0]                reg_addr_in,
	input wire logic [7:0]                reg_wdata_in,
	input wire logic [7:0]                reg_rdata_out,
	input wire video_regs_pkg::settings_t settings_out
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic w_shape = reg_wr_in && reg_addr_in == 8'h39;
	wire logic w_fmt   = reg_wr_in && reg_addr_in == 8'h3F;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_tau_decode: assert property (w_shape |=> settings_out.time_const_16th ==
		($past(reg_wdata_in[2:0]) == 3'h7 ? 4'h8 : {1'h0, $past(reg_wdata_in[2:0])})) else $error("tau decode");
	a_amp_decode: assert property (w_shape |=> settings_out.amplitude_atten_4th ==
		($past(reg_wdata_in[4:3]) == 2'h3 ? 3'h4 : {1'h0, $past(reg_wdata_in[4:3])})) else $error("amp decode");
	a_under_decode: assert property (w_shape |=> settings_out.undershoot_atten_4th ==
		($past(reg_wdata_in[6:5]) == 2'h3 ? 3'h4 : {1'h0, $past(reg_wdata_in[6:5])})) else $error("under decode");
	a_thr_step: assert property (reg_wr_in && reg_addr_in == 8'h3A |=>
		settings_out.noise_threshold == {$past(reg_wdata_in[3:0]), 3'h0}) else $error("threshold step");
	a_fill_chroma: assert property (reg_wr_in && reg_addr_in == 8'h3B |=>
		{settings_out.fill_v, settings_out.fill_u} == $past(reg_wdata_in)) else $error("chroma fill");
	a_range_levels: assert property (w_fmt |=> settings_out.black_level ==
		($past(reg_wdata_in[2]) ? 10'h040 : 10'h120) && settings_out.white_level == ($past(reg_wdata_in[2]) ? 10'h3FF : 10'h2FF))
		else $error("range levels");
	a_luma_code: assert property (w_fmt |=> settings_out.luma_advance == 3'h7 - $past(reg_wdata_in[6:4]) &&
		settings_out.chroma_invert == $past(reg_wdata_in[3])) else $error("luma code");
	a_unmapped_read: assert property (reg_rd_in && (reg_addr_in < 8'h39 || reg_addr_in > 8'h3F) |=>
		reg_rdata_out == 8'h00) else $error("unmapped read");
endmodule
`default_nettype wire

/* File: sim/host_model.sv */
// Purpose: Host side of the subaddress register port
// Assumes: Strobes change at falling edges only
// Notes:   Released write data is inverted so it never lingers
`default_nettype none
module host_model (
	// Register port
	input  wire logic       clk_in,
	output logic            wr_out,
	output logic            rd_out,
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out,
	input  wire logic [7:0] rdata_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{wr_out, rd_out, addr_out, wdata_out} = 18'h00000;
	end
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d & (a == 8'h3A ? 8'h0F : (a == 8'h39 || a == 8'h3F) ? 8'h7F : 8'hFF);
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		wdata_out = ~d;
	endtask
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

/* File: sim/video_peaking_panel_output_regs_tb.sv */
// Purpose: Self-checking bench for the settings bank
// Assumes: Host model drives the register port
// Notes:   A pixel counter feeds luma and chroma every cycle
`default_nettype none
module video_peaking_panel_output_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                      clk_in   = 1'b0;
	logic                      rst_n_in = 1'b0;
	logic                      wr, rd, hit;
	logic [7:0]                addr, wdata, rdata, rb, cu, cv;
	logic [9:0]                cnt = 10'h000;
	logic [9:0]                luma;
	logic [2:0]                c;
	video_regs_pkg::settings_t s;
	logic [7:0]                regs [7] = '{8'h7F, 8'h0F, 8'hA5, 8'h5A, 8'hC3, 8'h3C, 8'h76};
	int                        n_mismatch = 0;
	int                        samples_checked = 0;
	always #2.5 clk_in = ~clk_in;
	always @(negedge clk_in) cnt <= cnt + 10'h001;
	host_model host_model_inst (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata),
		.rdata_in(rdata));
	video_peaking_panel_output_regs video_peaking_panel_output_regs_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.reg_hit_out(hit), .pix_en_in(1'b1), .luma_in(cnt), .chroma_u_in(cnt[7:0]), .chroma_v_in(~cnt[7:0]),
		.luma_out(luma), .chroma_u_out(cu), .chroma_v_out(cv), .settings_out(s));
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		@(negedge clk_in) rst_n_in = 1'b1;
		chk("black", s.black_level, 10'h120);
		for (int i = 0; i < 7; i++) begin
			host_model_inst.read(8'(8'h39 + i), rb);
			chk("reset", rb, 8'h00);
			host_model_inst.write(8'(8'h39 + i), regs[i]);
			host_model_inst.read(8'(8'h39 + i), rb);
			chk("readback", rb, regs[i]);
			chk("hit", hit, 1'b1);
		end
		chk("fill", {s.fill_v, s.fill_u, s.fill_y}, 16'hA55A);
		chk("pos", {s.begin_pos, s.end_pos}, 16'hC33C);
		host_model_inst.read(8'h40, rb);
		chk("unmapped", {rb, 7'h00, hit}, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			host_model_inst.write(8'h39, {1'b0, ~c[1:0], c[1:0], c});
			host_model_inst.write(8'h3A, {4'h0, c, c[0]});
			host_model_inst.write(8'h3F, {1'b0, c, c[0], c[1], c[1:0]});
			repeat (10) @(negedge clk_in);
			#1;
			chk("tau", s.time_const_16th, c == 3'h7 ? 4'h8 : {1'b0, c});
			chk("amp", s.amplitude_atten_4th, c[1:0] == 2'h3 ? 3'h4 : {1'b0, c[1:0]});
			chk("under", s.undershoot_atten_4th, c[1:0] == 2'h0 ? 3'h4 : {1'b0, ~c[1:0]});
			chk("thr", s.noise_threshold, {c, c[0], 3'h0});
			chk("fdel", s.border_fine_delay, c[1:0]);
			chk("levels", {s.range_10bit, s.white_level}, c[1] ? 11'h7FF : 11'h2FF);
			chk("black", s.black_level, c[1] ? 10'h040 : 10'h120);
			chk("luma", luma, 10'(cnt - 10'h001 - 10'(c)));
			chk("u", cu, c[0] ? 8'(~(cnt[7:0] - 8'h08)) : 8'(cnt[7:0] - 8'h08));
			chk("v", cv, c[0] ? 8'(cnt[7:0] - 8'h08) : 8'(~(cnt[7:0] - 8'h08)));
		end
		// Mid-run reset must return the bank to its cleared state
		@(negedge clk_in) rst_n_in = 1'b0;
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'b1;
		host_model_inst.read(8'h3F, rb);
		chk("reset format", rb, 8'h00);
		chk("reset range", {s.range_10bit, s.black_level}, 11'h120);
		end_sim;
	end
	initial begin
		repeat (5000) @(posedge clk_in);
		n_mismatch++;
		end_sim;
	end
endmodule
bind video_peaking_panel_output_regs video_regs_monitor video_regs_monitor_inst (.clk_in(clk_in),
	.rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .settings_out(settings_out));
`default_nettype wire
